// file: rtl/serial_clock_pkg.sv
/*
 * Shared constants and types for the three-line serial shift-clock and
 * pin-select block: register map, field layouts, clock-divider counts.
 * Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package serial_clock_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing: shift-clock rates and half periods in system clocks
    localparam int CLK_HZ  = 100_000_000;
    localparam int SLOW_HZ = 37_500;
    localparam int MID_HZ  = 75_000;
    localparam int FAST_HZ = 450_000;
    localparam int DIV_W   = 11;

    // a half period is a longest time, so integer division rounds down
    localparam logic [DIV_W-1:0] HALF_SLOW = DIV_W'(CLK_HZ / (2 * SLOW_HZ));
    localparam logic [DIV_W-1:0] HALF_MID  = DIV_W'(CLK_HZ / (2 * MID_HZ));
    localparam logic [DIV_W-1:0] HALF_FAST = DIV_W'(CLK_HZ / (2 * FAST_HZ));

    ////////////////////////////////////////////////////////////////////////
    // clock counter
    localparam int          CNT_W    = 4;
    localparam logic [3:0]  CNT_LAST = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // register map (byte addresses)
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] A_MODE     = 8'h00;
    localparam logic [7:0] A_DIR      = 8'h04;
    localparam logic [7:0] A_LATCH    = 8'h08;
    localparam logic [7:0] A_PINS     = 8'h0c;
    localparam logic [7:0] A_IRQ_ST   = 8'h10;
    localparam logic [7:0] A_IRQ_MASK = 8'h14;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    ////////////////////////////////////////////////////////////////////////
    // field layouts
    typedef enum logic [1:0] {
        SRC_EXT  = 2'b00,
        SRC_SLOW = 2'b01,
        SRC_MID  = 2'b10,
        SRC_FAST = 2'b11
    } shift_src_t;

    typedef struct packed {
        logic       transfer_start_wait_release;
        logic       serial_out_enable;
        shift_src_t shift_clock_select;
    } mode_t;

    typedef struct packed {
        logic clock_pin_direction_flag;
        logic out_pin_direction_flag;
        logic in_pin_direction_flag;
    } dir_t;

    typedef struct packed {
        logic abort;
        logic done;
    } irq_t;

    localparam logic [3:0] MODE_RST  = 4'h0;
    localparam logic [2:0] DIR_RST   = 3'h0;
    localparam logic [2:0] LATCH_RST = 3'h0;
    localparam logic [1:0] IRQ_RST   = 2'h0;
    // synchroniser reset levels (clock, out, in): the clock idles high, so
    // resetting it low would show a false edge once reset lets go
    localparam logic [2:0] PIN_IDLE  = 3'h4;

endpackage

// file: rtl/pin_sync.sv
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes each bit is an independent level; no bus coherence is given.
 */
`timescale 1ns/1ns
module pin_sync #(
    parameter int           W       = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  logic         clk,
    input  logic         rst,
    input  logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    // the first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// file: rtl/shift_clock_divider.sv
/*
 * Internal shift-clock generator: a half-period counter and a level.
 * Assumes the caller drops run while the link waits; idle level is high.
 */
`timescale 1ns/1ns
module shift_clock_divider
    import serial_clock_pkg::*;
(
    input  logic             clk,
    input  logic             rst,
    input  logic             run,
    input  shift_src_t       src,
    output logic             level_q,
    output logic [DIV_W-1:0] div_q
);

    logic [DIV_W-1:0] half;

    always_comb begin
        case (src)
            SRC_SLOW: half = HALF_SLOW;
            SRC_MID:  half = HALF_MID;
            default:  half = HALF_FAST;
        endcase
    end

    // restarting from zero on every release gives a fresh first half period
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            div_q   <= '0;
            level_q <= 1'b1;
        end else if (div_q == half - DIV_W'(1)) begin
            div_q   <= '0;
            level_q <= ~level_q;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    chk_idle_high: assert property (@(posedge clk) disable iff (rst)
        !run |=> level_q && div_q == '0)
        else $error("divider not idle high while stopped");

endmodule

// file: rtl/serial_clock_pins.sv
/*
 * Shift-clock control and pin selection of a three-line serial link: AXI4-Lite registers,
 * pin muxing, internal clock, 8-edge clock counter, wait control and a masked interrupt.
 * Assumes a shift register outside supplies its MSB on SO_DATA and takes SHIFT_CLK,
 * SI_DATA and LINK_WAIT; pin wires are resolved outside.
 */
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module serial_clock_pins
    import serial_clock_pkg::*;
(
    input  logic              REF_CLK,
    input  logic              RST,
    // AXI4-Lite slave
    input  logic [ADDR_W-1:0] AWADDR,
    input  logic              AWVALID,
    output logic              AWREADY,
    input  logic [31:0]       WDATA,
    input  logic [3:0]        WSTRB,
    input  logic              WVALID,
    output logic              WREADY,
    output logic [1:0]        BRESP,
    output logic              BVALID,
    input  logic              BREADY,
    input  logic [ADDR_W-1:0] ARADDR,
    input  logic              ARVALID,
    output logic              ARREADY,
    output logic [31:0]       RDATA,
    output logic [1:0]        RRESP,
    output logic              RVALID,
    input  logic              RREADY,
    // pins
    input  logic              SHIFT_CLOCK_PIN_I,
    output logic              SHIFT_CLOCK_PIN_O,
    output logic              SHIFT_CLOCK_PIN_OE,
    input  logic              SERIAL_OUT_PIN_I,
    output logic              SERIAL_OUT_PIN_O,
    output logic              SERIAL_OUT_PIN_OE,
    input  logic              SERIAL_IN_PIN_I,
    output logic              SERIAL_IN_PIN_O,
    output logic              SERIAL_IN_PIN_OE,
    // shift register side
    input  logic              SO_DATA,
    output logic              SHIFT_CLK,
    output logic              SI_DATA,
    output logic              LINK_WAIT,
    output logic              IRQ
);

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    mode_t            mode_q;
    dir_t             dir_q;
    logic [2:0]       latch_q;
    irq_t             irq_st_q;
    irq_t             irq_mask_q;
    logic [CNT_W-1:0] cnt_q;
    logic [2:0]       pins_s;
    logic             sck_prev_q;
    logic             gen_level;
    logic [DIV_W-1:0] gen_div;
    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              aw_held_q;
    logic              w_held_q;
    logic              wr_go;
    logic              wr_hit;
    assign wr_go = aw_held_q && w_held_q && !BVALID;

    always_comb begin
        if (awaddr_q == A_MODE || awaddr_q == A_DIR || awaddr_q == A_LATCH
                || awaddr_q == A_IRQ_ST || awaddr_q == A_IRQ_MASK) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // address and data are taken in either order; one write at a time
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            AWREADY   <= 1'b0;
            WREADY    <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            BVALID    <= 1'b0;
            BRESP     <= RESP_OKAY;
        end else begin
            AWREADY <= !aw_held_q && !(AWVALID && AWREADY) && !BVALID;
            WREADY  <= !w_held_q && !(WVALID && WREADY) && !BVALID;
            if (AWVALID && AWREADY) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_held_q <= 1'b1;
                wdata_q  <= WDATA;
                wstrb_q  <= WSTRB;
            end
            if (wr_go) begin
                BVALID <= 1'b1;
                BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (BVALID && BREADY) begin
                BVALID    <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
            end
        end
    end

    logic  mode_wr;
    mode_t wr_mode;
    assign mode_wr = wr_go && awaddr_q == A_MODE && wstrb_q[0];
    assign wr_mode = mode_t'(wdata_q[3:0]);
    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    logic [31:0] rd_word;
    logic        rd_hit;
    // the clock counter is deliberately absent from the map
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        if (ARADDR == A_MODE) begin
            rd_word[3:0] = mode_q;
        end else if (ARADDR == A_DIR) begin
            rd_word[2:0] = dir_q;
        end else if (ARADDR == A_LATCH) begin
            rd_word[2:0] = latch_q;
        end else if (ARADDR == A_PINS) begin
            rd_word[3:0] = {LINK_WAIT, pins_s};
        end else if (ARADDR == A_IRQ_ST) begin
            rd_word[1:0] = irq_st_q;
        end else if (ARADDR == A_IRQ_MASK) begin
            rd_word[1:0] = irq_mask_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= '0;
            RRESP   <= RESP_OKAY;
        end else begin
            ARREADY <= !RVALID && !(ARVALID && ARREADY);
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RDATA  <= rd_word;
                RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // pin sampling and shift-clock edges
    pin_sync #(
        .W       (3),
        .RST_VAL (PIN_IDLE)
    ) u_pin_sync (
        .clk (REF_CLK),
        .rst (RST),
        .d   ({SHIFT_CLOCK_PIN_I, SERIAL_OUT_PIN_I, SERIAL_IN_PIN_I}),
        .q   (pins_s)
    );

    logic running;
    logic int_sel;
    logic rise;
    logic fall;
    logic last_rise;
    assign running   = mode_q.transfer_start_wait_release;
    assign int_sel   = mode_q.shift_clock_select != SRC_EXT;
    // the pin is read back whatever drives it, our clock or the partner's
    assign rise      = pins_s[2] && !sck_prev_q;
    assign fall      = !pins_s[2] && sck_prev_q;
    assign last_rise = running && rise && cnt_q == CNT_LAST;
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sck_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= pins_s[2];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // mode, direction, latch registers and wait control
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            mode_q <= mode_t'(MODE_RST);
        end else if (mode_wr) begin
            // rewriting a running link with release leaves it running
            mode_q <= wr_mode;
        end else if (last_rise) begin
            mode_q.transfer_start_wait_release <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            dir_q   <= dir_t'(DIR_RST);
            latch_q <= LATCH_RST;
        end else if (wr_go && wstrb_q[0]) begin
            if (awaddr_q == A_DIR) begin
                dir_q <= dir_t'(wdata_q[2:0]);
            end else if (awaddr_q == A_LATCH) begin
                latch_q <= wdata_q[2:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // clock counter
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            cnt_q <= '0;
        end else if (mode_wr && !wr_mode.transfer_start_wait_release) begin
            cnt_q <= '0;
        end else if (running) begin
            if (rise && cnt_q == CNT_LAST) begin
                cnt_q <= '0;
            end else if (fall) begin
                cnt_q <= cnt_q + CNT_W'(1);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // internal clock generator, master only
    shift_clock_divider u_div (
        .clk     (REF_CLK),
        .rst     (RST),
        .run     (running && int_sel),
        .src     (mode_q.shift_clock_select),
        .level_q (gen_level),
        .div_q   (gen_div)
    );
    ////////////////////////////////////////////////////////////////////////
    // pin drivers and shift-register side, all registered
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            SHIFT_CLOCK_PIN_O  <= 1'b1;
            SHIFT_CLOCK_PIN_OE <= 1'b0;
            SERIAL_OUT_PIN_O   <= 1'b0;
            SERIAL_OUT_PIN_OE  <= 1'b0;
            SERIAL_IN_PIN_O    <= 1'b0;
            SERIAL_IN_PIN_OE   <= 1'b0;
            SHIFT_CLK          <= 1'b1;
            SI_DATA            <= 1'b0;
            LINK_WAIT          <= 1'b1;
        end else begin
            // slave with flag 0 leaves the pin undriven
            SHIFT_CLOCK_PIN_OE <= dir_q.clock_pin_direction_flag;
            SHIFT_CLOCK_PIN_O  <= int_sel ? gen_level : latch_q[2];
            SERIAL_OUT_PIN_OE  <= dir_q.out_pin_direction_flag;
            SERIAL_OUT_PIN_O   <= mode_q.serial_out_enable ? SO_DATA : latch_q[1];
            SERIAL_IN_PIN_OE   <= dir_q.in_pin_direction_flag;
            SERIAL_IN_PIN_O    <= latch_q[0];
            // an output-mode serial-in pin feeds the shifter its own latch
            SI_DATA            <= dir_q.in_pin_direction_flag ? latch_q[0] : pins_s[0];
            SHIFT_CLK          <= pins_s[2];
            LINK_WAIT          <= !running;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, write one to clear, set beats clear
    irq_t irq_set;
    irq_t irq_clr;
    logic irq_any;

    assign irq_set.done  = last_rise;
    assign irq_set.abort = mode_wr && !wr_mode.transfer_start_wait_release && running;
    assign irq_clr       = (wr_go && wstrb_q[0] && awaddr_q == A_IRQ_ST) ?
                           irq_t'(wdata_q[1:0]) : irq_t'(IRQ_RST);
    assign irq_any       = |(irq_st_q & irq_mask_q);

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            irq_st_q <= irq_t'(IRQ_RST);
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            irq_mask_q <= irq_t'(IRQ_RST);
        end else if (wr_go && wstrb_q[0] && awaddr_q == A_IRQ_MASK) begin
            irq_mask_q <= irq_t'(wdata_q[1:0]);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= irq_any;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_last_rise;
        running && rise && cnt_q == CNT_LAST && !mode_wr;
    endsequence
    sequence s_release_master;
        !running && int_sel && mode_wr && wr_mode.transfer_start_wait_release
            && wr_mode.shift_clock_select != SRC_EXT;
    endsequence
    chk_wrap_to_wait: assert property (
        s_last_rise |=> cnt_q == '0 && !running ##1 LINK_WAIT)
        else $error("count eight did not end in wait");
    chk_release_fresh: assert property (
        s_release_master |=> gen_level && gen_div == '0 ##1 running)
        else $error("release did not restart the clock");
    chk_forced_zero: assert property (
        mode_wr && !wr_mode.transfer_start_wait_release |=> cnt_q == '0 && !running)
        else $error("forced wait left counter nonzero");
    chk_wait_frozen: assert property (
        !running && !$past(running) && !$past(mode_wr) |-> cnt_q == $past(cnt_q))
        else $error("counter moved while waiting");
    chk_fall_count: assert property (
        running && fall && cnt_q < CNT_LAST && !mode_wr |=> cnt_q == $past(cnt_q) + 4'h1)
        else $error("falling edge not counted");
    chk_count_range: assert property (
        cnt_q <= CNT_LAST)
        else $error("counter passed eight");
    // the direction flag is needed in both cycles: a write may turn the pin round
    chk_wait_high: assert property (
        int_sel && !running && dir_q.clock_pin_direction_flag && !mode_wr
            ##1 int_sel && !running && dir_q.clock_pin_direction_flag
            |=> SHIFT_CLOCK_PIN_O && SHIFT_CLOCK_PIN_OE)
        else $error("clock pin not high in wait");
    chk_slave_input: assert property (
        !int_sel && !dir_q.clock_pin_direction_flag |=> !SHIFT_CLOCK_PIN_OE)
        else $error("slave clock pin driven");
    chk_serial_out: assert property (
        mode_q.serial_out_enable && dir_q.out_pin_direction_flag
            |=> SERIAL_OUT_PIN_OE && SERIAL_OUT_PIN_O == $past(SO_DATA))
        else $error("serial out pin not carrying data");
    chk_serial_in: assert property (
        !dir_q.in_pin_direction_flag |=> !SERIAL_IN_PIN_OE ##0 SI_DATA == $past(pins_s[0]))
        else $error("serial in pin not an input");
    chk_irq_level: assert property (
        irq_any |=> IRQ)
        else $error("unmasked status without interrupt");

endmodule

// file: test/serial_peer.sv
/*
 * Far-side serial peer and the three pin wires.
 * Assumes the bench calls burst() only while the clock pin is an input.
 */
`timescale 1ns/1ns
module serial_peer (
    input  wire logic clk_o,
    input  wire logic clk_oe,
    input  wire logic so_o,
    input  wire logic so_oe,
    input  wire logic si_o,
    input  wire logic si_oe,
    output logic      clk_pin,
    output logic      so_pin,
    output logic      si_pin
);
    logic ext_clk = 1'b1;
    logic si_bit  = 1'b0;
    // outside clock stands still high between frames
    assign clk_pin = clk_oe ? clk_o : ext_clk;
    // serial-out line is pulled up when nobody drives it
    assign so_pin  = so_oe ? so_o : 1'b1;
    assign si_pin  = si_oe ? si_o : si_bit;
    task automatic burst(input int n);
        repeat (n) begin
            #40 ext_clk = 1'b0;
            si_bit = ~si_bit;
            #40 ext_clk = 1'b1;
        end
    endtask
endmodule

// file: test/serial_clock_pins_test.sv
/*
 * Self-checking bench for the serial clock and pin-select block.
 * Assumes the peer model resolves the pins and the register map of the package.
 */
`timescale 1ns/1ns
module serial_clock_pins_test;
    import serial_clock_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  awaddr  = 8'h00;
    logic [7:0]  araddr  = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d;
    logic        ck_o, ck_oe, so_o, so_oe, si_o, si_oe, ck_pin, so_pin, si_pin;
    logic        shift_clk, si_data, link_wait, irq;
    logic        so_data = 1'b0;
    int          miscompares = 0;
    int          total_checks = 0;
    int          falls = 0;
    realtime     t_fall = 0;
    realtime     per = 0;

    initial forever #5 ref_clk = ~ref_clk;
    always @(negedge ck_pin) begin
        per = $realtime - t_fall;
        t_fall = $realtime;
        falls++;
    end

    serial_clock_pins serial_clock_pins_inst (
        .REF_CLK(ref_clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .SHIFT_CLOCK_PIN_I(ck_pin), .SHIFT_CLOCK_PIN_O(ck_o), .SHIFT_CLOCK_PIN_OE(ck_oe),
        .SERIAL_OUT_PIN_I(so_pin), .SERIAL_OUT_PIN_O(so_o), .SERIAL_OUT_PIN_OE(so_oe),
        .SERIAL_IN_PIN_I(si_pin), .SERIAL_IN_PIN_O(si_o), .SERIAL_IN_PIN_OE(si_oe),
        .SO_DATA(so_data), .SHIFT_CLK(shift_clk), .SI_DATA(si_data),
        .LINK_WAIT(link_wait), .IRQ(irq)
    );
    serial_peer serial_peer_inst (
        .clk_o(ck_o), .clk_oe(ck_oe), .so_o(so_o), .so_oe(so_oe), .si_o(si_o),
        .si_oe(si_oe), .clk_pin(ck_pin), .so_pin(so_pin), .si_pin(si_pin)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wait_link(input logic lvl);
        int k;
        k = 0;
        while (link_wait !== lvl && k < 40000) begin
            @(posedge ref_clk);
            k++;
        end
        check(link_wait, lvl, "link wait level");
    endtask

    task automatic wait_falls(input int n);
        int k;
        k = 0;
        while (falls < n && k < 4000) begin
            @(posedge ref_clk);
            k++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(A_MODE);
        check(d, 32'h0, "mode reset");
        check(link_wait, 1'b1, "waits at reset");
        check(ck_oe, 1'b0, "clock pin input");
        rd(8'h40);
        check(r, RESP_SLVERR, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_rates();
        int hz[3] = '{37_500, 75_000, 450_000};
        int half;
        wr(A_DIR, 32'h6);
        check(r, RESP_OKAY, "write okay");
        rd(A_DIR);
        check(d, 32'h6, "direction readback");
        wr(A_IRQ_MASK, 32'h1);
        wr(A_MODE, 32'h7);
        repeat (4) @(posedge ref_clk);
        check(ck_oe, 1'b1, "clock pin driven");
        check(ck_o, 1'b1, "high while waiting");
        check(so_oe, 1'b1, "serial out driven");
        check(si_oe, 1'b0, "serial in input");
        so_data <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check(so_pin, 1'b1, "serial out data");
        check(si_data, si_pin, "serial in to shifter");
        for (int i = 0; i < 3; i++) begin
            half = 100_000_000 / (2 * hz[i]);
            falls = 0;
            wr(A_MODE, 32'hc | (i + 1));
            wait_link(1'b0);
            wait_link(1'b1);
            check(falls, 8, "eight clocks");
            check(int'(per), 20 * half, "clock period");
            check(ck_pin, 1'b1, "stops high");
            check(shift_clk, 1'b1, "shift clock idle high");
            check(irq, 1'b1, "done raises irq");
            wr(A_IRQ_ST, 32'h1);
            repeat (3) @(posedge ref_clk);
            check(irq, 1'b0, "irq cleared");
        end
        $display("test rates done");
    endtask

    task automatic t_abort();
        wr(A_IRQ_MASK, 32'h2);
        falls = 0;
        wr(A_MODE, 32'hf);
        wait_falls(2);
        wr(A_MODE, 32'hf);
        wait_link(1'b1);
        check(falls, 8, "re-release keeps count");
        falls = 0;
        wr(A_MODE, 32'hf);
        wait_falls(4);
        wr(A_MODE, 32'h7);
        repeat (500) @(posedge ref_clk);
        check(falls, 4, "clock stopped");
        check(ck_pin, 1'b1, "stopped high");
        check(irq, 1'b1, "abort raises irq");
        rd(A_IRQ_ST);
        check(d[1], 1'b1, "abort status");
        wr(A_IRQ_ST, 32'h3);
        falls = 0;
        wr(A_MODE, 32'hf);
        wait_link(1'b0);
        wait_link(1'b1);
        check(falls, 8, "counter was zeroed");
        $display("test abort done");
    endtask

    task automatic t_slave();
        wr(A_DIR, 32'h1);
        wr(A_LATCH, 32'h1);
        wr(A_MODE, 32'h8);
        repeat (4) @(posedge ref_clk);
        check(ck_oe, 1'b0, "slave clock input");
        check(so_oe, 1'b0, "out pin input");
        check(si_oe, 1'b1, "in pin output");
        check(si_o, 1'b1, "in pin latch");
        check(si_data, 1'b1, "latch to shifter");
        check(link_wait, 1'b0, "slave released");
        wr(A_IRQ_ST, 32'h3);
        falls = 0;
        serial_peer_inst.burst(7);
        repeat (10) @(posedge ref_clk);
        check(link_wait, 1'b0, "seven edges keep running");
        serial_peer_inst.burst(1);
        repeat (10) @(posedge ref_clk);
        check(link_wait, 1'b1, "slave eight edges");
        rd(A_IRQ_ST);
        check(d[0], 1'b1, "slave done status");
        $display("test slave done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #800_000;
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_rates();
        t_abort();
        t_slave();
        complete_run();
    end
endmodule
